/* include/tmr8_pkg.sv */
// constants for the 8-bit timer with waveform generator
package tmr8_pkg;
    localparam logic [7:0] TMR8_OFS_CTRL   = 8'h00;
    localparam logic [7:0] TMR8_OFS_COUNT  = 8'h04;
    localparam logic [7:0] TMR8_OFS_CMP    = 8'h08;
    localparam logic [7:0] TMR8_OFS_FLAGS  = 8'h0c;
    localparam logic [7:0] TMR8_OFS_PIN    = 8'h10;
    localparam int TMR8_BIT_FORCE   = 7;
    localparam int TMR8_BIT_WGM_LO  = 6;
    localparam int TMR8_BIT_COM_HI  = 5;
    localparam int TMR8_BIT_COM_LO  = 4;
    localparam int TMR8_BIT_WGM_HI  = 3;
    localparam int TMR8_BIT_CS_HI   = 2;
    localparam int TMR8_BIT_CS_LO   = 0;
    localparam int TMR8_BIT_OVF     = 1;
    localparam int TMR8_BIT_CMPF    = 0;
    localparam int TMR8_BIT_DIR     = 0;
    localparam int TMR8_BIT_PORT    = 1;
    localparam logic [7:0] TMR8_CTRL_RESET = 8'h00;
    localparam logic [7:0] TMR8_MAX        = 8'hff;
    localparam logic [7:0] TMR8_BOTTOM     = 8'h00;
    localparam logic [1:0] TMR8_WGM_NORMAL = 2'h0;
    localparam logic [1:0] TMR8_WGM_PCPWM  = 2'h1;
    localparam logic [1:0] TMR8_WGM_CTC    = 2'h2;
    localparam logic [1:0] TMR8_WGM_FAST   = 2'h3;
    localparam logic [1:0] TMR8_COM_OFF    = 2'h0;
    localparam logic [1:0] TMR8_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TMR8_COM_CLEAR  = 2'h2;
    localparam logic [1:0] TMR8_COM_SET    = 2'h3;
    localparam logic [2:0] TMR8_CS_STOP    = 3'h0;
    localparam logic [2:0] TMR8_CS_DIV1    = 3'h1;
    localparam logic [2:0] TMR8_CS_DIV8    = 3'h2;
    localparam logic [2:0] TMR8_CS_DIV64   = 3'h3;
    localparam logic [2:0] TMR8_CS_DIV256  = 3'h4;
    localparam logic [2:0] TMR8_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TMR8_CS_EXTFALL = 3'h6;
    localparam logic [2:0] TMR8_CS_EXTRISE = 3'h7;
    localparam int TMR8_PRE_W = 10;
    localparam logic [9:0] TMR8_PRE_M8    = 10'h007;
    localparam logic [9:0] TMR8_PRE_M64   = 10'h03f;
    localparam logic [9:0] TMR8_PRE_M256  = 10'h0ff;
    localparam logic [9:0] TMR8_PRE_M1024 = 10'h3ff;
    localparam int TMR8_PCPWM_PERIOD = 510;
    localparam logic [1:0] TMR8_RESP_OKAY   = 2'h0;
    localparam logic [1:0] TMR8_RESP_SLVERR = 2'h2;
endpackage

/* logic/tmr8_timer.sv */
// 8-bit timer/counter with compare unit, waveform generator and axi4-lite slave
`timescale 1ns/1ps
`default_nettype none

// How it works
// - phase-correct counts up then down repeatedly
// - max held one timer tick at turnaround
// - phase-correct overflow flag set at bottom
// - phase-correct top fixed at 0xff
// - phase-correct period is 510 timer ticks
// - phase-correct: clear up, set down; inverted
// - phase-correct: compare zero low, compare max high; inverted
// - counting synchronous, timer clock is enable
// - force strobe applies match action in non-pwm
// - force sets no flag, never clears counter
// - force reads zero, ignored in pwm
// - mode bits 6,3 pick counting mode, top
// - nonzero output mode drives pin if output
// - non-pwm: off, toggle, clear, set on match
// - fast pwm: clear/set on match, opposite at top
// - compare equals top in pwm with com1: skip match
// - clock select: stop, prescaler taps, pin edges
// - pin edges counted even when pin output
// - overflow flag cleared by writing one
// - counter write blocks next compare match
// - compare flag set on match, write-one clears
// - output mode change acts at next match
module tmr8_timer (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        external_count_pin,
    output logic             compare_output_pin,
    output logic             compare_output_pin_oe,
    output logic             overflow_flag,
    output logic             compare_flag
);
    logic [7:0]  ctrl_q;
    logic [7:0]  count_value_q;
    logic [7:0]  cmp_buf_q;
    logic [7:0]  compare_value_q;
    logic        ovf_q;
    logic        cmpf_q;
    logic        wave_q;
    logic        down_q;
    logic        block_q;
    logic [1:0]  pin_cfg_q;
    logic [9:0]  pre_q;
    logic [2:0]  ext_sync_q;
    logic        tick;
    logic [1:0]  wgm;
    logic [1:0]  com;
    logic [2:0]  cs;
    logic        pwm;
    logic [7:0]  top;
    logic        at_top;
    logic        match;
    logic        match_ok;
    logic        ovf_set;
    logic [7:0]  count_d;
    logic        down_d;
    logic        wave_d;
    logic        force_hit;
    logic [1:0]  act_com;

    // axi write path state
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic        wr_lane0;
    logic [7:0]  wr_byte;

    assign wgm = {ctrl_q[tmr8_pkg::TMR8_BIT_WGM_HI], ctrl_q[tmr8_pkg::TMR8_BIT_WGM_LO]};
    assign com = ctrl_q[tmr8_pkg::TMR8_BIT_COM_HI:tmr8_pkg::TMR8_BIT_COM_LO];
    assign cs  = ctrl_q[tmr8_pkg::TMR8_BIT_CS_HI:tmr8_pkg::TMR8_BIT_CS_LO];
    assign pwm = (wgm == tmr8_pkg::TMR8_WGM_PCPWM) || (wgm == tmr8_pkg::TMR8_WGM_FAST);
    assign top = (wgm == tmr8_pkg::TMR8_WGM_CTC) ? compare_value_q : tmr8_pkg::TMR8_MAX;
    assign at_top = (count_value_q == top);

    function automatic logic [31:0] tmr8_ofs(input logic [7:0] a);
        tmr8_ofs = {24'h000000, a[7:2], 2'h0};
    endfunction

    // free-running prescaler and pin sampler
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 10'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync_q <= '0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], external_count_pin};
        end
    end

    // timer clock enable qualifying each count step
    always_comb begin
        unique case (cs)
            tmr8_pkg::TMR8_CS_STOP:    tick = 1'b0;
            tmr8_pkg::TMR8_CS_DIV1:    tick = 1'b1;
            tmr8_pkg::TMR8_CS_DIV8:    tick = ((pre_q & tmr8_pkg::TMR8_PRE_M8) == tmr8_pkg::TMR8_PRE_M8);
            tmr8_pkg::TMR8_CS_DIV64:   tick = ((pre_q & tmr8_pkg::TMR8_PRE_M64) == tmr8_pkg::TMR8_PRE_M64);
            tmr8_pkg::TMR8_CS_DIV256:  tick = ((pre_q & tmr8_pkg::TMR8_PRE_M256) == tmr8_pkg::TMR8_PRE_M256);
            tmr8_pkg::TMR8_CS_DIV1024: tick = (pre_q == tmr8_pkg::TMR8_PRE_M1024);
            tmr8_pkg::TMR8_CS_EXTFALL: tick = ext_sync_q[2] && !ext_sync_q[1];
            tmr8_pkg::TMR8_CS_EXTRISE: tick = !ext_sync_q[2] && ext_sync_q[1];
        endcase
    end

    // compare match, suppressed after a counter write and at top in pwm when com bit 1 is set
    assign match = (count_value_q == compare_value_q) && !block_q;
    assign match_ok = tick && match &&
        !(pwm && com[1] && compare_value_q == tmr8_pkg::TMR8_MAX);

    // counting sequence
    always_comb begin
        count_d = count_value_q;
        down_d  = down_q;
        ovf_set = 1'b0;
        if (tick) begin
            if (wgm == tmr8_pkg::TMR8_WGM_PCPWM) begin
                if (!down_q && count_value_q == tmr8_pkg::TMR8_MAX) begin
                    down_d  = 1'b1; // direction flips at max; count steps down this tick
                    count_d = count_value_q - 8'h01;
                end else if (down_q && count_value_q == tmr8_pkg::TMR8_BOTTOM) begin
                    down_d  = 1'b0;
                    count_d = count_value_q + 8'h01;
                    ovf_set = 1'b1;
                end else if (down_q) begin
                    count_d = count_value_q - 8'h01;
                end else begin
                    count_d = count_value_q + 8'h01;
                end
            end else begin
                down_d = 1'b0;
                if (wgm == tmr8_pkg::TMR8_WGM_CTC && match) begin
                    count_d = tmr8_pkg::TMR8_BOTTOM;
                end else begin
                    count_d = count_value_q + 8'h01;
                end
                ovf_set = (count_value_q == tmr8_pkg::TMR8_MAX);
            end
        end
    end

    // waveform generator
    assign force_hit = wr_fire && wr_lane0 && (tmr8_ofs(aw_addr_q) == 32'(tmr8_pkg::TMR8_OFS_CTRL))
        && wr_byte[tmr8_pkg::TMR8_BIT_FORCE] && !pwm;
    // a forced compare acts with the output mode written alongside the strobe
    assign act_com = force_hit ? wr_byte[tmr8_pkg::TMR8_BIT_COM_HI:tmr8_pkg::TMR8_BIT_COM_LO] : com;
    always_comb begin
        wave_d = wave_q;
        if (!pwm) begin
            if (match_ok || force_hit) begin
                unique case (act_com)
                    tmr8_pkg::TMR8_COM_OFF:    wave_d = wave_q;
                    tmr8_pkg::TMR8_COM_TOGGLE: wave_d = !wave_q;
                    tmr8_pkg::TMR8_COM_CLEAR:  wave_d = 1'b0;
                    tmr8_pkg::TMR8_COM_SET:    wave_d = 1'b1;
                endcase
            end
        end else if (com[1]) begin
            if (wgm == tmr8_pkg::TMR8_WGM_FAST) begin
                if (tick && at_top) begin
                    wave_d = !com[0];
                end else if (match_ok) begin
                    wave_d = com[0];
                end
            end else if (tick) begin
                // compare at bottom stays low, at max stays high; opposite when inverted
                if (compare_value_q == tmr8_pkg::TMR8_MAX) begin
                    wave_d = !com[0];
                end else if (compare_value_q == tmr8_pkg::TMR8_BOTTOM) begin
                    wave_d = com[0];
                end else if (match_ok) begin
                    wave_d = down_q ? !com[0] : com[0];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_q <= 1'b0;
            down_q <= 1'b0;
        end else begin
            wave_q <= wave_d;
            down_q <= down_d;
        end
    end

    // axi4-lite write channel capture
    assign wr_fire  = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_lane0 = w_strb_q[0];
    assign wr_byte  = w_data_q[7:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tmr8_pkg::TMR8_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (tmr8_ofs(aw_addr_q))
                    32'(tmr8_pkg::TMR8_OFS_CTRL), 32'(tmr8_pkg::TMR8_OFS_COUNT), 32'(tmr8_pkg::TMR8_OFS_CMP),
                    32'(tmr8_pkg::TMR8_OFS_FLAGS), 32'(tmr8_pkg::TMR8_OFS_PIN):
                        s_axi_bresp <= tmr8_pkg::TMR8_RESP_OKAY;
                    default: s_axi_bresp <= tmr8_pkg::TMR8_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // control register; force bit is never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q    <= tmr8_pkg::TMR8_CTRL_RESET;
            pin_cfg_q <= '0;
        end else if (wr_fire && wr_lane0) begin
            if (tmr8_ofs(aw_addr_q) == 32'(tmr8_pkg::TMR8_OFS_CTRL)) begin
                ctrl_q <= {1'b0, wr_byte[6:0]};
            end
            if (tmr8_ofs(aw_addr_q) == 32'(tmr8_pkg::TMR8_OFS_PIN)) begin
                pin_cfg_q <= wr_byte[1:0];
            end
        end
    end

    // counter; a software write wins and blocks the next match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_value_q <= '0;
            block_q       <= 1'b0;
        end else if (wr_fire && wr_lane0 && tmr8_ofs(aw_addr_q) == 32'(tmr8_pkg::TMR8_OFS_COUNT)) begin
            count_value_q <= wr_byte;
            block_q       <= 1'b1;
        end else begin
            count_value_q <= count_d;
            if (tick) begin
                block_q <= 1'b0;
            end
        end
    end

    // compare register with buffer loaded at top in pwm modes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_buf_q       <= '0;
            compare_value_q <= '0;
        end else begin
            if (wr_fire && wr_lane0 && tmr8_ofs(aw_addr_q) == 32'(tmr8_pkg::TMR8_OFS_CMP)) begin
                cmp_buf_q <= wr_byte;
                if (!pwm) begin
                    compare_value_q <= wr_byte;
                end
            end else if (pwm && tick && count_value_q == tmr8_pkg::TMR8_MAX && !down_q) begin
                compare_value_q <= cmp_buf_q;
            end
        end
    end

    // sticky flags: hardware set wins over write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_q  <= 1'b0;
            cmpf_q <= 1'b0;
        end else begin
            if (ovf_set) begin
                ovf_q <= 1'b1;
            end else if (wr_fire && wr_lane0 && tmr8_ofs(aw_addr_q) == 32'(tmr8_pkg::TMR8_OFS_FLAGS)
                         && wr_byte[tmr8_pkg::TMR8_BIT_OVF]) begin
                ovf_q <= 1'b0;
            end
            if (match_ok) begin
                cmpf_q <= 1'b1;
            end else if (wr_fire && wr_lane0 && tmr8_ofs(aw_addr_q) == 32'(tmr8_pkg::TMR8_OFS_FLAGS)
                         && wr_byte[tmr8_pkg::TMR8_BIT_CMPF]) begin
                cmpf_q <= 1'b0;
            end
        end
    end

    // pin driver and flag outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_output_pin    <= 1'b0;
            compare_output_pin_oe <= 1'b0;
            overflow_flag         <= 1'b0;
            compare_flag          <= 1'b0;
        end else begin
            compare_output_pin    <= (com != tmr8_pkg::TMR8_COM_OFF) ? wave_d : pin_cfg_q[tmr8_pkg::TMR8_BIT_PORT];
            compare_output_pin_oe <= pin_cfg_q[tmr8_pkg::TMR8_BIT_DIR];
            overflow_flag         <= ovf_q;
            compare_flag          <= cmpf_q;
        end
    end

    // axi4-lite read channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= tmr8_pkg::TMR8_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= tmr8_pkg::TMR8_RESP_OKAY;
                unique case (tmr8_ofs(s_axi_araddr))
                    32'(tmr8_pkg::TMR8_OFS_CTRL):  s_axi_rdata <= {24'h000000, ctrl_q};
                    32'(tmr8_pkg::TMR8_OFS_COUNT): s_axi_rdata <= {24'h000000, count_value_q};
                    32'(tmr8_pkg::TMR8_OFS_CMP):   s_axi_rdata <= {24'h000000, cmp_buf_q};
                    32'(tmr8_pkg::TMR8_OFS_FLAGS): s_axi_rdata <= {30'h00000000, ovf_q, cmpf_q};
                    32'(tmr8_pkg::TMR8_OFS_PIN):   s_axi_rdata <= {29'h00000000, wave_q, pin_cfg_q};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= tmr8_pkg::TMR8_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    sequence pc_turn_s;
        tick && !down_q && count_value_q == tmr8_pkg::TMR8_MAX;
    endsequence

    pc_turn_a: assert property (@(posedge clk) disable iff (!rst_n)
        ((wgm == tmr8_pkg::TMR8_WGM_PCPWM && !wr_fire) and pc_turn_s) |=> down_q && count_value_q == 8'hfe)
        else $error("turnaround did not start counting down");
    pc_bottom_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wgm == tmr8_pkg::TMR8_WGM_PCPWM && tick && down_q && count_value_q == 8'h00) |=> ovf_q)
        else $error("overflow not set at bottom");
    pc_no_max_ovf_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wgm == tmr8_pkg::TMR8_WGM_PCPWM && $rose(ovf_q)) |-> $past(count_value_q) == 8'h00)
        else $error("phase-correct overflow away from bottom");
    force_noflag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (force_hit && !match_ok && !cmpf_q) |=> !cmpf_q)
        else $error("forced compare set the flag");
    ctrl_force_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_q[tmr8_pkg::TMR8_BIT_FORCE])
        else $error("force bit stored");
    count_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(block_q) |-> !match_ok)
        else $error("match after counter write");
    ovf_set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        ovf_set |=> ovf_q)
        else $error("overflow event lost");
    cmp_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        match_ok |=> cmpf_q ##1 compare_flag)
        else $error("compare flag not raised");
    fast_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wgm == tmr8_pkg::TMR8_WGM_FAST && com == tmr8_pkg::TMR8_COM_CLEAR && tick && at_top) |=> wave_q)
        else $error("fast pwm not set at top");
    stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cs == tmr8_pkg::TMR8_CS_STOP && !wr_fire) |=> $stable(count_value_q))
        else $error("stopped counter moved");
endmodule

`default_nettype wire

/* testbench/tmr8_count_source.sv */
// model of the external circuit that drives the count pin
`timescale 1ns/1ps
`default_nettype none
module tmr8_count_source #(
    parameter int PULSES = 5,
    parameter int HALF   = 4
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      external_count_pin,
    output logic      busy
);
    logic [7:0] edges_q;
    logic [3:0] div_q;
    logic       pin_q;
    // each half period spans several system clocks so sampling is safe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edges_q <= 8'h00;
            div_q   <= 4'h0;
            pin_q   <= 1'b0;
        end else if (start && edges_q == 8'h00) begin
            edges_q <= 8'(2 * PULSES);
            div_q   <= 4'h0;
        end else if (edges_q != 8'h00) begin
            if (div_q == 4'(HALF - 1)) begin
                div_q   <= 4'h0;
                pin_q   <= ~pin_q;
                edges_q <= edges_q - 8'h01;
            end else begin
                div_q <= div_q + 4'h1;
            end
        end
    end
    assign external_count_pin = pin_q;
    assign busy               = edges_q != 8'h00;
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, start = 0;
    logic [7:0]  awaddr = 0, araddr = 0, c;
    logic [31:0] wdata = 0, rdata, rv;
    logic [3:0]  wstrb = 4'h1;
    logic        awready, wready, bvalid, arready, rvalid, pin, oe, ovf, cmpf, ext, busy, cur;
    logic [1:0]  bresp, rresp, rr, com;
    integer      fail_count = 0, cmp_count = 0, seed = 32'hca2d, i, n, hi, lo;
    tmr8_timer DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .external_count_pin(ext),
        .compare_output_pin(pin), .compare_output_pin_oe(oe), .overflow_flag(ovf), .compare_flag(cmpf));
    tmr8_count_source SRC (.clk(clk), .rst_n(rst_n), .start(start), .external_count_pin(ext), .busy(busy));
    initial forever #4 clk = ~clk;
    task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        d = rdata; r = rresp; rready <= 0;
    endtask
    task lvl(input logic v, output integer t);
        t = 0;
        while (pin !== v && t < 2000) begin @(posedge clk); t++; end
    endtask
    function logic nxt(input logic [1:0] m, input logic p);
        return m == 2'h1 ? ~p : m == 2'h3;
    endfunction
    initial begin
        #(8 * 60000);
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        rd(tmr8_pkg::TMR8_OFS_CTRL, rv, rr); check("ctrl reset", 32'h0, rv);
        rd(8'h20, rv, rr); check("unmapped resp", {30'h0, tmr8_pkg::TMR8_RESP_SLVERR}, {30'h0, rr});
        wr(tmr8_pkg::TMR8_OFS_PIN, 8'h01);
        cur = 0;
        for (i = 0; i < 4; i++) begin
            com = i == 0 ? 2'h3 : i == 1 ? 2'h2 : 2'h1;
            wr(tmr8_pkg::TMR8_OFS_CTRL, 8'h80 | {2'h0, com, 4'h0});
            repeat (3) @(posedge clk);
            cur = nxt(com, cur);
            check("forced pin", {31'h0, cur}, {31'h0, pin});
        end
        rd(tmr8_pkg::TMR8_OFS_CTRL, rv, rr); check("force reads zero", 32'h0, {24'h0, rv[7], 7'h0});
        check("force no flag", 32'h0, {31'h0, cmpf});
        check("pin driven", 32'h1, {31'h0, oe});
        $display("test force done");
        wr(tmr8_pkg::TMR8_OFS_CTRL, 8'h00);
        wr(tmr8_pkg::TMR8_OFS_CMP, 8'hf8);
        wr(tmr8_pkg::TMR8_OFS_COUNT, 8'hf0);
        wr(tmr8_pkg::TMR8_OFS_CTRL, 8'h01);
        repeat (30) @(posedge clk);
        check("overflow set", 32'h1, {31'h0, ovf});
        check("compare set", 32'h1, {31'h0, cmpf});
        wr(tmr8_pkg::TMR8_OFS_CTRL, 8'h00);
        wr(tmr8_pkg::TMR8_OFS_FLAGS, 8'h03);
        rd(tmr8_pkg::TMR8_OFS_FLAGS, rv, rr); check("flags cleared", 32'h0, rv);
        wr(tmr8_pkg::TMR8_OFS_COUNT, 8'h00);
        wr(tmr8_pkg::TMR8_OFS_CMP, 8'h10);
        wr(tmr8_pkg::TMR8_OFS_CTRL, 8'h09);
        repeat (400) @(posedge clk);
        rd(tmr8_pkg::TMR8_OFS_COUNT, rv, rr); check("ctc top", 32'h1, {31'h0, rv <= 32'h10});
        wr(tmr8_pkg::TMR8_OFS_CTRL, 8'h00);
        $display("test flags done");
        for (i = 0; i < 2; i++) begin
            wr(tmr8_pkg::TMR8_OFS_COUNT, 8'h00);
            wr(tmr8_pkg::TMR8_OFS_CTRL, i == 0 ? 8'h07 : 8'h06);
            start <= 1; @(posedge clk); start <= 0; @(posedge clk);
            for (n = 0; n < 200 && busy; n++) @(posedge clk);
            repeat (6) @(posedge clk);
            rd(tmr8_pkg::TMR8_OFS_COUNT, rv, rr); check("pin edges", 32'h5, rv);
            wr(tmr8_pkg::TMR8_OFS_CTRL, 8'h00);
        end
        $display("test external done");
        for (i = 0; i < 2; i++) begin
            c = 8'h01 + 8'($unsigned($random(seed)) % 254);
            wr(tmr8_pkg::TMR8_OFS_CMP, c);
            wr(tmr8_pkg::TMR8_OFS_CTRL, i == 0 ? 8'h61 : 8'h71);
            repeat (1100) @(posedge clk);
            lvl(0, n); lvl(1, n); lvl(0, hi); lvl(1, lo);
            check("pwm high", i == 0 ? 2 * c : 510 - 2 * c, hi);
            check("pwm period", tmr8_pkg::TMR8_PCPWM_PERIOD, hi + lo);
        end
        for (i = 0; i < 2; i++) begin
            wr(tmr8_pkg::TMR8_OFS_CMP, i == 0 ? 8'h00 : 8'hff);
            wr(tmr8_pkg::TMR8_OFS_CTRL, 8'h61);
            repeat (600) @(posedge clk);
            n = 0;
            repeat (600) begin @(posedge clk); if (pin !== (i == 1)) n++; end
            check("pwm constant", 32'h0, n);
        end
        $display("test pwm done");
        print_verdict();
    end
endmodule
`default_nettype wire
